// ---- doca_pkg.sv ----
package doca_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int AUX_W = 10;
  localparam int AUX_HI_W = 8;
  localparam int AUX_LO_W = 2;
  localparam int LVL_W = 8;
  localparam int SUM_W = 18;
  localparam int NCH = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 32;
  localparam int FIFO_CNT_W = 4;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLIP = 8'h04;
  localparam logic [7:0] ADDR_OFS_A = 8'h08;
  localparam logic [7:0] ADDR_OFS_B = 8'h0C;
  localparam logic [7:0] ADDR_AUXH_A = 8'h10;
  localparam logic [7:0] ADDR_AUXL_A = 8'h14;
  localparam logic [7:0] ADDR_AUXH_B = 8'h18;
  localparam logic [7:0] ADDR_AUXL_B = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_LIM_BIT = 0;
  localparam int CTRL_TC_BIT = 1;
  localparam int STAT_LVL_LSB = 4;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [7:0] CLIP_RST = 8'hFF;
  localparam logic [15:0] OFS_RST = 16'h0000;
  localparam logic [7:0] AUXH_RST = 8'h00;
  localparam logic [1:0] AUXL_RST = 2'h0;

  // ****************************************
  // Datapath constants
  // ****************************************
  localparam int CLIP_SHIFT = 7;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic signed [17:0] SAT_MAX = 18'sh07FFF;
  localparam logic signed [17:0] SAT_MIN = 18'sh38000;

endpackage : doca_pkg

// ---- doca_fifo.sv ----
`timescale 1ns/100ps
module doca_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data,
  // Fill level
  output logic [CW-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic wr_ready_q, wr_ready_d, rd_valid_q, rd_valid_d;
  logic push, pop;

  // Ready and valid are registered from the next fill count, so both stay honest.
  always_comb begin
    push = wr_valid && wr_ready_q;
    pop = rd_valid_q && rd_ready;
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
    wr_ready_d = (cnt_d != CW'(DEPTH));
    rd_valid_d = (cnt_d != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      wr_ready_q <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      wr_ready_q <= wr_ready_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_q] <= wr_data;
    end
  end

  assign wr_ready = wr_ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = mem[rp_q];
  assign level = cnt_q;

endmodule : doca_fifo

// ---- doca_top.sv ----
`timescale 1ns/100ps
module doca_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample stream from the earlier datapath
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [doca_pkg::DATA_W-1:0] in_a,
  input wire logic [doca_pkg::DATA_W-1:0] in_b,
  // Samples to the converter cores
  output logic out_valid,
  input wire logic out_ready,
  output logic [doca_pkg::DATA_W-1:0] out_a,
  output logic [doca_pkg::DATA_W-1:0] out_b,
  // Auxiliary converter codes
  output logic [doca_pkg::AUX_W-1:0] aux_a,
  output logic [doca_pkg::AUX_W-1:0] aux_b
);
  import doca_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [1:0] ctrl_q, ctrl_d;
  logic [LVL_W-1:0] clip_lvl_q, clip_lvl_d;
  logic [DATA_W-1:0] ofs_q [NCH];
  logic [DATA_W-1:0] ofs_d [NCH];
  logic [AUX_HI_W-1:0] auxh_q [NCH];
  logic [AUX_HI_W-1:0] auxh_d [NCH];
  logic [AUX_LO_W-1:0] auxl_q [NCH];
  logic [AUX_LO_W-1:0] auxl_d [NCH];
  logic [NCH-1:0] seen_q, seen_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [FIFO_CNT_W-1:0] fifo_lvl;
  logic [NCH-1:0] hit;
  logic pop;
  logic setup, wr_take;

  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready_q && pwrite;

  always_comb begin
    ctrl_d = ctrl_q;
    clip_lvl_d = clip_lvl_q;
    ofs_d = ofs_q;
    auxh_d = auxh_q;
    auxl_d = auxl_q;
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    seen_d = seen_q;
    if (setup) begin
      pslverr_d = 1'b0;
      case (paddr)
        ADDR_CTRL: prdata_d = {30'h0, ctrl_q};
        ADDR_CLIP: prdata_d = {24'h0, clip_lvl_q};
        ADDR_OFS_A: prdata_d = {16'h0, ofs_q[0]};
        ADDR_OFS_B: prdata_d = {16'h0, ofs_q[1]};
        ADDR_AUXH_A: prdata_d = {24'h0, auxh_q[0]};
        ADDR_AUXL_A: prdata_d = {30'h0, auxl_q[0]};
        ADDR_AUXH_B: prdata_d = {24'h0, auxh_q[1]};
        ADDR_AUXL_B: prdata_d = {30'h0, auxl_q[1]};
        ADDR_STAT: prdata_d = {24'h0, fifo_lvl, 2'h0, seen_q};
        default: begin
          prdata_d = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (wr_take) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = pwdata[1:0];
        ADDR_CLIP: clip_lvl_d = pwdata[LVL_W-1:0];
        ADDR_OFS_A: ofs_d[0] = pwdata[DATA_W-1:0];
        ADDR_OFS_B: ofs_d[1] = pwdata[DATA_W-1:0];
        ADDR_AUXH_A: auxh_d[0] = pwdata[AUX_HI_W-1:0];
        ADDR_AUXL_A: auxl_d[0] = pwdata[AUX_LO_W-1:0];
        ADDR_AUXH_B: auxh_d[1] = pwdata[AUX_HI_W-1:0];
        ADDR_AUXL_B: auxl_d[1] = pwdata[AUX_LO_W-1:0];
        ADDR_STAT: seen_d = seen_q & ~pwdata[NCH-1:0];
        default: ;
      endcase
    end
    // A clip event in the clearing cycle must not be lost, so setting wins.
    seen_d = seen_d | (hit & {NCH{pop}});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      clip_lvl_q <= CLIP_RST;
      for (int i = 0; i < NCH; i++) begin
        ofs_q[i] <= OFS_RST;
        auxh_q[i] <= AUXH_RST;
        auxl_q[i] <= AUXL_RST;
      end
      seen_q <= '0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      clip_lvl_q <= clip_lvl_d;
      ofs_q <= ofs_d;
      auxh_q <= auxh_d;
      auxl_q <= auxl_d;
      seen_q <= seen_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign aux_a = {auxh_q[0], auxl_q[0]};
  assign aux_b = {auxh_q[1], auxl_q[1]};

  // ****************************************
  // Input buffer
  // ****************************************
  logic fifo_vld;
  logic [FIFO_W-1:0] fifo_dat;
  logic out_vld_q, out_vld_d;
  logic [DATA_W-1:0] samp_q [NCH];
  logic [DATA_W-1:0] samp_d [NCH];

  // The cores can stall through out_ready, which backs up into in_ready.
  doca_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .CW(FIFO_CNT_W)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_b, in_a}),
    .rd_valid(fifo_vld),
    .rd_ready(!out_vld_q || out_ready),
    .rd_data(fifo_dat),
    .level(fifo_lvl)
  );

  assign pop = fifo_vld && (!out_vld_q || out_ready);

  // ****************************************
  // Limiter and offset, one lane per channel
  // ****************************************
  logic lim_en, coding_tc;
  logic signed [SUM_W-1:0] lim_s;
  logic [DATA_W-1:0] raw [NCH];
  logic signed [SUM_W-1:0] in_s [NCH];
  logic signed [SUM_W-1:0] clip_s [NCH];
  logic signed [SUM_W-1:0] sum_s [NCH];

  assign lim_en = ctrl_q[CTRL_LIM_BIT];
  assign coding_tc = ctrl_q[CTRL_TC_BIT];
  assign lim_s = signed'({3'h0, clip_lvl_q, 7'h00});

  for (genvar ch = 0; ch < NCH; ch++) begin : g_lane
    always_comb begin
      logic [DATA_W-1:0] s16;
      s16 = '0;
      raw[ch] = fifo_dat[ch*DATA_W +: DATA_W];
      // Everything after this point works in two's complement until the output returns to offset binary.
      s16 = coding_tc ? raw[ch] : (raw[ch] ^ MID_CODE);
      in_s[ch] = signed'({{2{s16[DATA_W-1]}}, s16});
      clip_s[ch] = in_s[ch];
      hit[ch] = 1'b0;
      if (lim_en && (in_s[ch] > lim_s)) begin
        clip_s[ch] = lim_s;
        hit[ch] = 1'b1;
      end else if (lim_en && (in_s[ch] < -lim_s)) begin
        clip_s[ch] = -lim_s;
        hit[ch] = 1'b1;
      end
      // Offset is sign-extended so all ones means minus one.
      sum_s[ch] = clip_s[ch] + signed'({{2{ofs_q[ch][DATA_W-1]}}, ofs_q[ch]});
      samp_d[ch] = samp_q[ch];
      if (pop) begin
        // Clamping keeps a large offset from folding the output over.
        if (sum_s[ch] > SAT_MAX) begin
          samp_d[ch] = 16'hFFFF;
        end else if (sum_s[ch] < SAT_MIN) begin
          samp_d[ch] = 16'h0000;
        end else begin
          samp_d[ch] = sum_s[ch][DATA_W-1:0] ^ MID_CODE;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        samp_q[ch] <= MID_CODE;
      end else begin
        samp_q[ch] <= samp_d[ch];
      end
    end

    a_clip_bound: assert property (@(posedge pclk) disable iff (!presetn)
      pop && lim_en |-> (clip_s[ch] <= lim_s) && (clip_s[ch] >= -lim_s))
      else $error("clipped sample outside limiter bounds");
    a_clip_bypass: assert property (@(posedge pclk) disable iff (!presetn)
      pop && !lim_en |-> clip_s[ch] == in_s[ch])
      else $error("limiter acted while disabled");
    a_coding_sel: assert property (@(posedge pclk) disable iff (!presetn)
      pop && !coding_tc |-> in_s[ch][DATA_W-1:0] == (raw[ch] ^ MID_CODE))
      else $error("binary input not shifted to mid scale");
    a_offset_add: assert property (@(posedge pclk) disable iff (!presetn)
      pop && (sum_s[ch] <= SAT_MAX) && (sum_s[ch] >= SAT_MIN)
      |=> samp_q[ch] == ($past(sum_s[ch][DATA_W-1:0]) ^ MID_CODE))
      else $error("offset not applied to output sample");
    a_sat_high: assert property (@(posedge pclk) disable iff (!presetn)
      pop && (sum_s[ch] > SAT_MAX) |=> samp_q[ch] == 16'hFFFF && out_vld_q)
      else $error("positive overflow not saturated");
    a_sat_low: assert property (@(posedge pclk) disable iff (!presetn)
      pop && (sum_s[ch] < SAT_MIN) |=> samp_q[ch] == 16'h0000 && out_vld_q)
      else $error("negative overflow not saturated");
    a_seen_set: assert property (@(posedge pclk) disable iff (!presetn)
      pop && hit[ch] |=> seen_q[ch])
      else $error("clip event not recorded");
    a_clip_level: assert property (@(posedge pclk) disable iff (!presetn)
      pop && lim_en && (in_s[ch] > lim_s)
      |-> (clip_s[ch][6:0] == 7'h00) && (clip_s[ch][14:7] == clip_lvl_q) && (clip_s[ch][17:15] == 3'h0))
      else $error("clip level not 128 times the setting");
    a_ofs_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pop && (ofs_q[ch] == 16'h0000)
      |=> samp_q[ch] == ($past(clip_s[ch][DATA_W-1:0]) ^ MID_CODE))
      else $error("zero offset changed the sample");
    a_ofs_minus: assert property (@(posedge pclk) disable iff (!presetn)
      pop && (ofs_q[ch] == 16'hFFFF) && (clip_s[ch] > SAT_MIN)
      |=> samp_q[ch] == (16'($past(clip_s[ch][DATA_W-1:0]) - 16'h0001) ^ MID_CODE))
      else $error("all-ones offset did not subtract one");
    a_tc_pass: assert property (@(posedge pclk) disable iff (!presetn)
      pop && coding_tc |-> in_s[ch][DATA_W-1:0] == raw[ch])
      else $error("two's complement input altered on entry");
    a_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
      out_vld_q && !out_ready |=> out_vld_q && $stable(samp_q[ch]))
      else $error("stalled sample changed before acceptance");
  end

  // ****************************************
  // Output handshake
  // ****************************************
  always_comb begin
    out_vld_d = out_vld_q;
    if (pop) begin
      out_vld_d = 1'b1;
    end else if (out_ready) begin
      out_vld_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_vld_q <= 1'b0;
    end else begin
      out_vld_q <= out_vld_d;
    end
  end

  assign out_valid = out_vld_q;
  assign out_a = samp_q[0];
  assign out_b = samp_q[1];

  // ****************************************
  // Register checks
  // ****************************************

  a_aux_low: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == ADDR_AUXL_A |=> aux_a[1:0] == $past(pwdata[1:0]))
    else $error("aux low bits not taken from low field");
  a_aux_high: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == ADDR_AUXH_B |=> aux_b[9:2] == $past(pwdata[7:0]) ##1 $stable(aux_b))
    else $error("aux high bits not taken from high field");
  a_aux_a_high: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == ADDR_AUXH_A |=> aux_a[9:2] == $past(pwdata[7:0]))
    else $error("aux A high bits not taken from high field");
  a_aux_b_low: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == ADDR_AUXL_B |=> aux_b[1:0] == $past(pwdata[1:0]))
    else $error("aux B low bits not taken from low field");

endmodule : doca_top

// ---- doca_core_sink.sv ----
`timescale 1ns/100ps
module doca_core_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Share of cycles in percent that the cores hold off; 100 stalls them fully
  input wire logic [7:0] stall_pct,
  // Sample handshake
  output logic out_ready
);
  int seed = 32'h5EED0001;

  // The cores take samples promptly or slowly at random, never during reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($unsigned($random(seed)) % 100) >= stall_pct;
    end
  end
endmodule : doca_core_sink

// ---- testbench.sv ----
`timescale 1ns/100ps
`define CHK(g, e, w) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", w, e, g); end end
module testbench;
  import doca_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, stall = 8'h00, lvl;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, in_valid = 1'b0, in_ready, out_valid, out_ready, er, tc, lim;
  logic [15:0] in_a = 16'h0, in_b = 16'h0, out_a, out_b, ofs_a, ofs_b, ea, eb;
  logic [9:0] aux_a, aux_b;
  logic [15:0] qa[$], qb[$];
  logic [1:0] seen_e = 2'h0;
  int seed = 32'hA916DFC4;
  int miscompares = 0, samples_checked = 0, n;

  always #2.5 pclk = ~pclk;

  doca_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_a(in_a), .in_b(in_b),
    .out_valid(out_valid), .out_ready(out_ready), .out_a(out_a), .out_b(out_b),
    .aux_a(aux_a), .aux_b(aux_b));
  doca_core_sink core_u (.pclk(pclk), .presetn(presetn), .stall_pct(stall),
    .out_ready(out_ready));

  // ****************************************
  // Expected datapath result
  // ****************************************
  function automatic logic [15:0] expect_f(logic [15:0] x, logic [15:0] ofs);
    int s;
    int lim_v;
    lim_v = 128 * int'(lvl);
    s = tc ? int'($signed(x)) : int'($signed(x ^ 16'h8000));
    if (lim && s > lim_v) s = lim_v;
    if (lim && s < -lim_v) s = -lim_v;
    s = s + int'($signed(ofs));
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return 16'(s) ^ 16'h8000;
  endfunction : expect_f

  function automatic logic hit_f(logic [15:0] x);
    int s;
    s = tc ? int'($signed(x)) : int'($signed(x ^ 16'h8000));
    return lim && (s > 128 * int'(lvl) || s < -128 * int'(lvl));
  endfunction : hit_f

  always @(posedge pclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      `CHK(qa.size() > 0, 1'b1, "sample expected")
      if (qa.size() > 0) begin
        ea = qa.pop_front();
        eb = qb.pop_front();
        `CHK(out_a, ea, "out_a")
        `CHK(out_b, eb, "out_b")
      end
    end
  end

  // ****************************************
  // Bus and stream tasks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    `CHK(pready, 1'b1, "apb ready")
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task send(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      in_valid <= 1'b1;
      in_a <= (i % 7 == 0) ? 16'h7FFF : 16'($random(seed));
      in_b <= (i % 5 == 0) ? 16'h8000 : 16'($random(seed));
      @(posedge pclk);
      while (in_ready !== 1'b1) @(posedge pclk);
      qa.push_back(expect_f(in_a, ofs_a));
      qb.push_back(expect_f(in_b, ofs_b));
      seen_e = seen_e | {hit_f(in_b), hit_f(in_a)};
    end
    in_valid <= 1'b0;
  endtask : send

  task drain;
    n = 0;
    while (qa.size() != 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(qa.size(), 0, "drained")
  endtask : drain

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #300000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(aux_a, 10'h000, "aux_a reset")
    `CHK(out_a, 16'h8000, "out_a reset")
    `CHK(out_valid, 1'b0, "out_valid reset")
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[1:0], CTRL_RST, "ctrl reset")
    apb(1'b0, ADDR_CLIP, 32'h0);
    `CHK(rd[7:0], CLIP_RST, "clip reset")
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    `CHK(er, 1'b1, "unmapped error")
    for (int k = 0; k < 8; k++) begin
      tc = k[0];
      lim = k[1] | (k > 5);
      lvl = (k == 2) ? 8'h00 : (k == 3) ? 8'hFF : 8'($random(seed));
      ofs_a = (k == 4) ? 16'h7FFF : (k == 5) ? 16'h8000 : 16'($random(seed));
      ofs_b = (k == 4) ? 16'h8000 : (k == 6) ? 16'hFFFF : 16'($random(seed));
      apb(1'b1, ADDR_CTRL, {30'h0, tc, lim});
      apb(1'b1, ADDR_CLIP, {24'h0, lvl});
      apb(1'b1, ADDR_OFS_A, {16'h0, ofs_a});
      apb(1'b1, ADDR_OFS_B, {16'h0, ofs_b});
      apb(1'b1, ADDR_AUXH_A, {24'h0, lvl});
      apb(1'b1, ADDR_AUXL_A, {30'h0, ~2'(k)});
      apb(1'b1, ADDR_AUXH_B, {24'h0, ofs_a[7:0]});
      apb(1'b1, ADDR_AUXL_B, {30'h0, 2'(k)});
      `CHK(aux_a, {lvl, ~2'(k)}, "aux_a")
      `CHK(aux_b, {ofs_a[7:0], 2'(k)}, "aux_b")
      apb(1'b0, ADDR_AUXL_B, 32'h0);
      `CHK(rd[1:0], 2'(k), "aux_b low read")
      stall <= 8'(k * 12);
      send(24);
      drain();
      apb(1'b0, ADDR_STAT, 32'h0);
      `CHK(rd[7:0], {6'h00, seen_e}, "status")
      apb(1'b1, ADDR_STAT, 32'h3);
      seen_e = 2'h0;
    end
    stall <= 8'd100;
    repeat (3) @(posedge pclk);
    in_valid <= 1'b1;
    in_a <= 16'h0123;
    in_b <= 16'hFEDC;
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (in_ready === 1'b1) begin
        qa.push_back(expect_f(16'h0123, ofs_a));
        qb.push_back(expect_f(16'hFEDC, ofs_b));
      end
    end
    in_valid <= 1'b0;
    `CHK(in_ready, 1'b0, "buffer full")
    `CHK(qa.size(), FIFO_DEPTH + 1, "buffer depth")
    stall <= 8'd30;
    drain();
    summarize();
  end
endmodule : testbench
